// *** hdl/csv_chan_vector.sv ***
`timescale 1ns/1ps
`default_nettype none

module csv_chan_vector
  import csv_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic srst,
  // Receive side events from the engine and the processor.
  input wire logic rx_deliver,
  input wire logic rx_partial,
  input wire logic rx_crc_err,
  input wire logic rx_stop,
  input wire logic rx_abort,
  input wire logic rx_taken,
  // Transmit side events.
  input wire logic tx_consumed,
  input wire logic tx_written,
  // Status word and overrun event.
  output logic [CSV_VEC_BITS-1:0] vec,
  output logic overrun
);

  logic partial;
  logic crc_err;
  logic stop;
  logic abort;
  logic full;
  logic empty;

  // End-of-message flags are rewritten by every delivered octet, so a clean octet clears them.
  always_ff @(posedge clk) begin
    if (srst) begin
      partial <= 1'b0;
      crc_err <= 1'b0;
      stop <= 1'b0;
      abort <= 1'b0;
    end else if (rx_deliver) begin
      partial <= rx_partial;
      crc_err <= rx_crc_err;
      stop <= rx_stop | rx_abort;
      abort <= rx_abort;
    end else if (rx_taken) begin
      partial <= 1'b0;
      crc_err <= 1'b0;
      stop <= 1'b0;
      abort <= 1'b0;
    end
  end

  // A new octet wins over the processor taking the old one in the same cycle.
  always_ff @(posedge clk) begin
    if (srst) begin
      full <= 1'b0;
    end else if (rx_deliver) begin
      full <= 1'b1;
    end else if (rx_taken) begin
      full <= 1'b0;
    end
  end

  // The slot starts empty; consumption wins over a simultaneous refill.
  always_ff @(posedge clk) begin
    if (srst) begin
      empty <= CSV_EMPTY_RESET;
    end else if (tx_consumed) begin
      empty <= 1'b1;
    end else if (tx_written) begin
      empty <= 1'b0;
    end
  end

  // Summary bit follows the two slot flags with no extra delay.
  always_comb begin
    vec = '0;
    vec[CSV_BIT_PARTIAL] = partial;
    vec[CSV_BIT_CRC] = crc_err;
    vec[CSV_BIT_STOP] = stop;
    vec[CSV_BIT_ABORT] = abort;
    vec[CSV_BIT_FULL] = full;
    vec[CSV_BIT_EMPTY] = empty;
    vec[CSV_BIT_FLAG] = full | empty;
  end

  // An octet arriving over one still unread is lost.
  assign overrun = rx_deliver & full & ~rx_taken;

  chk_abort_sets_stop: assert property (@(posedge clk) disable iff (srst)
    rx_deliver && rx_abort |=> vec[CSV_BIT_ABORT] && vec[CSV_BIT_STOP])
    else $error("Abort did not raise abort and stop together.");

  chk_partial_follows: assert property (@(posedge clk) disable iff (srst)
    rx_deliver |=> vec[CSV_BIT_PARTIAL] == $past(rx_partial))
    else $error("Partial octet flag does not match delivered octet.");

  chk_crc_follows: assert property (@(posedge clk) disable iff (srst)
    rx_deliver |=> vec[CSV_BIT_CRC] == $past(rx_crc_err))
    else $error("CRC error flag does not match delivered octet.");

  chk_full_on_deliver: assert property (@(posedge clk) disable iff (srst)
    rx_deliver |=> vec[CSV_BIT_FULL] && vec[CSV_BIT_FLAG])
    else $error("Receive full or summary flag missing after delivery.");

  chk_empty_on_consume: assert property (@(posedge clk) disable iff (srst)
    tx_consumed |=> vec[CSV_BIT_EMPTY] && vec[CSV_BIT_FLAG])
    else $error("Transmit empty or summary flag missing after consumption.");

  chk_stop_on_close: assert property (@(posedge clk) disable iff (srst)
    rx_deliver && rx_stop |=> vec[CSV_BIT_STOP])
    else $error("Stop flag missing after closing flag.");

endmodule

`default_nettype wire

// *** hdl/csv_irq.sv ***
`timescale 1ns/1ps
`default_nettype none

module csv_irq
  import csv_pkg::*;
#(
  parameter int W = CSV_IRQ_W
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic srst,
  // Event inputs, one cycle each.
  input wire logic [W-1:0] event_in,
  // Software writes.
  input wire logic clear_wr,
  input wire logic mask_wr,
  input wire logic [W-1:0] wr_data,
  // Results.
  output logic [W-1:0] status,
  output logic [W-1:0] mask,
  output logic irq
);

  logic [W-1:0] next_status;
  logic [W-1:0] next_mask;

  // Write-one-to-clear, but an event in the same cycle keeps its bit set.
  always_comb begin
    next_status = status;
    if (clear_wr) begin
      next_status = status & ~wr_data;
    end
    next_status = next_status | event_in;
    next_mask = mask_wr ? wr_data : mask;
  end

  // Status and mask registers.
  always_ff @(posedge clk) begin
    if (srst) begin
      status <= '0;
      mask <= W'(CSV_IRQ_MASK_RESET);
    end else begin
      status <= next_status;
      mask <= next_mask;
    end
  end

  // The line is registered from the next values so it tracks status with no lag.
  always_ff @(posedge clk) begin
    if (srst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(next_status & next_mask);
    end
  end

  chk_irq_level: assert property (@(posedge clk) disable iff (srst)
    irq == |(status & mask))
    else $error("Interrupt line disagrees with status and mask.");

endmodule

`default_nettype wire

// *** hdl/csv_pkg.sv ***
package csv_pkg;

  // Bus and array shape.
  localparam int CSV_ADDR_W = 16;
  localparam int CSV_DATA_W = 32;
  localparam int CSV_NUM_CHANNELS = 32;
  localparam int CSV_VEC_BITS = 7;

  // Word indexes of the registers; a byte address is four times the index.
  localparam logic [15:0] CSV_VEC_BASE_IDX = 16'h40A0;
  localparam logic [15:0] CSV_CTRL_IDX = 16'h4100;
  localparam logic [15:0] CSV_IRQ_STAT_IDX = 16'h4101;
  localparam logic [15:0] CSV_IRQ_MASK_IDX = 16'h4102;

  // Field positions inside one channel status vector word.
  localparam int CSV_BIT_PARTIAL = 0;
  localparam int CSV_BIT_CRC = 1;
  localparam int CSV_BIT_STOP = 2;
  localparam int CSV_BIT_ABORT = 3;
  localparam int CSV_BIT_FULL = 4;
  localparam int CSV_BIT_EMPTY = 5;
  localparam int CSV_BIT_FLAG = 6;

  // Control register field.
  localparam int CSV_CTRL_OWN_BIT = 0;

  // Interrupt status and mask layout.
  localparam int CSV_IRQ_W = 6;
  localparam int CSV_IRQ_RX_FULL = 0;
  localparam int CSV_IRQ_TX_EMPTY = 1;
  localparam int CSV_IRQ_ABORT = 2;
  localparam int CSV_IRQ_CRC = 3;
  localparam int CSV_IRQ_OVERRUN = 4;
  localparam int CSV_IRQ_DENIED = 5;

  // Reset values.
  localparam logic CSV_OWN_RESET = 1'b0;
  localparam logic CSV_EMPTY_RESET = 1'b1;
  localparam logic [5:0] CSV_IRQ_MASK_RESET = 6'h00;

endpackage

// *** hdl/csv_top.sv ***
// What this block does
// - Each channel exposes a read-only seven-flag status word guiding slot reads and writes.
// - Status words are readable only while the processor owns the engine.
// - Bit 0 flags a received message ending in an incomplete octet, else zero.
// - Bit 1 flags a failed frame check on a received message, else zero.
// - Bit 2 rises when a closing flag is seen in the receive direction.
// - Seven consecutive ones raise bit 3 abort and bit 2 stop together.
// - Bit 4 rises whenever a new octet lands in the receive slot.
// - Bit 5 rises once the transmit slot octet is consumed; zero means still held.
// - An unrefilled empty transmit slot makes the engine resend the previous octet.
// - Bit 6 becomes one as soon as receive full or transmit empty is one.
// - Thirty-two channels, one status word each at consecutive addresses.
//
// Decided for this implementation: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module csv_top
  import csv_pkg::*;
#(
  parameter int NUM_CHANNELS = CSV_NUM_CHANNELS,
  parameter int CH_W = $clog2(CSV_NUM_CHANNELS)
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic srst,
  // Avalon-MM slave, word addressed.
  input wire logic [CSV_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [CSV_DATA_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [CSV_DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  // Receive events from the engine.
  input wire logic rx_deliver,
  input wire logic [CH_W-1:0] rx_channel,
  input wire logic rx_partial,
  input wire logic rx_crc_err,
  input wire logic rx_stop,
  input wire logic rx_abort,
  // Receive slot taken by the processor.
  input wire logic rx_taken,
  input wire logic [CH_W-1:0] rx_taken_channel,
  // Transmit slot events.
  input wire logic tx_consumed,
  input wire logic [CH_W-1:0] tx_consumed_channel,
  input wire logic tx_written,
  input wire logic [CH_W-1:0] tx_written_channel,
  // Processing session boundary.
  input wire logic session_start,
  // Outputs to the engine and system.
  output logic engine_owned_by_processor,
  output logic [NUM_CHANNELS-1:0] tx_repeat,
  output logic irq
);

  logic [CSV_VEC_BITS-1:0] vec_all [NUM_CHANNELS];
  logic [NUM_CHANNELS-1:0] overrun_all;
  logic [NUM_CHANNELS-1:0] empty_all;
  logic [CSV_ADDR_W-1:0] vec_off;
  logic is_vec;
  logic [CH_W-1:0] vec_sel;
  logic req;
  logic ack;
  logic wr_fire;
  logic lane0;
  logic [CSV_IRQ_W-1:0] irq_events;
  logic [CSV_IRQ_W-1:0] irq_status;
  logic [CSV_IRQ_W-1:0] irq_mask;
  logic [CSV_DATA_W-1:0] next_readdata;
  logic denied;

  // Qualifiers are shared by all channels and only the strobes are steered, so a channel
  // ignores whatever rides on the qualifier lines while it is not addressed.
  // One status word per channel; strobes are steered by channel number.
  for (genvar g = 0; g < NUM_CHANNELS; g++) begin : g_chan
    csv_chan_vector u_vec (
      .clk(clk),
      .srst(srst),
      .rx_deliver(rx_deliver && rx_channel == CH_W'(g)),
      .rx_partial(rx_partial),
      .rx_crc_err(rx_crc_err),
      .rx_stop(rx_stop),
      .rx_abort(rx_abort),
      .rx_taken(rx_taken && rx_taken_channel == CH_W'(g)),
      .tx_consumed(tx_consumed && tx_consumed_channel == CH_W'(g)),
      .tx_written(tx_written && tx_written_channel == CH_W'(g)),
      .vec(vec_all[g]),
      .overrun(overrun_all[g])
    );
    assign empty_all[g] = vec_all[g][CSV_BIT_EMPTY];

    // Every channel, not only the first, keeps its summary and abort flags consistent.
    chk_summary_each: assert property (@(posedge clk) disable iff (srst)
      vec_all[g][CSV_BIT_FLAG] == (vec_all[g][CSV_BIT_FULL] | vec_all[g][CSV_BIT_EMPTY]))
      else $error("Summary flag does not follow the slot flags.");

    chk_abort_has_stop: assert property (@(posedge clk) disable iff (srst)
      vec_all[g][CSV_BIT_ABORT] |-> vec_all[g][CSV_BIT_STOP])
      else $error("Abort flag stands without the stop flag.");

    // A lone take empties the receive slot; a delivery in the same cycle would win.
    chk_take_clears: assert property (@(posedge clk) disable iff (srst)
      rx_taken && rx_taken_channel == CH_W'(g) &&
      !(rx_deliver && rx_channel == CH_W'(g)) |=> !vec_all[g][CSV_BIT_FULL])
      else $error("Receive slot still full after it was taken.");
  end

  // The decoder subtracts the base once, so the window test and the channel select
  // share one subtractor. An index below the base fails the first comparison even
  // though the difference wraps high. Control, interrupt status and mask words lie
  // beyond the window; every other index reads as zero and ignores writes.
  // Status words sit at consecutive word indexes from the base.
  always_comb begin
    vec_off = avs_address - CSV_VEC_BASE_IDX;
    is_vec = (avs_address >= CSV_VEC_BASE_IDX) &&
             (vec_off < CSV_ADDR_W'(NUM_CHANNELS));
    vec_sel = vec_off[CH_W-1:0];
  end

  // Every transfer costs two cycles: the answer comes one edge after the request is
  // seen and the master completes on the edge after that. The registered answer
  // keeps the read multiplexer off the bus output path, which is cheap at this rate.
  // A request is answered one cycle after it appears; waitrequest idles high.
  assign req = avs_read | avs_write;
  assign ack = req & avs_waitrequest;
  assign wr_fire = avs_write & ~avs_waitrequest;
  assign lane0 = avs_byteenable[0];

  // Waitrequest drops for exactly the one cycle the master completes in.
  always_ff @(posedge clk) begin
    if (srst) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= ~ack;
    end
  end

  // Read mux; unmapped indexes and gated status reads answer zero.
  always_comb begin
    next_readdata = '0;
    denied = 1'b0;
    if (is_vec) begin
      if (engine_owned_by_processor) begin
        next_readdata = CSV_DATA_W'(vec_all[vec_sel]);
      end else begin
        denied = avs_read;
      end
    end else if (avs_address == CSV_CTRL_IDX) begin
      next_readdata[CSV_CTRL_OWN_BIT] = engine_owned_by_processor;
    end else if (avs_address == CSV_IRQ_STAT_IDX) begin
      next_readdata = CSV_DATA_W'(irq_status);
    end else if (avs_address == CSV_IRQ_MASK_IDX) begin
      next_readdata = CSV_DATA_W'(irq_mask);
    end
  end

  // Read data is captured with the answer and held until the next one.
  always_ff @(posedge clk) begin
    if (srst) begin
      avs_readdata <= '0;
    end else if (ack && avs_read) begin
      avs_readdata <= next_readdata;
    end
  end

  // Ownership bit; status words are writable by nobody, so writes there are dropped.
  always_ff @(posedge clk) begin
    if (srst) begin
      engine_owned_by_processor <= CSV_OWN_RESET;
    end else if (wr_fire && lane0 && avs_address == CSV_CTRL_IDX) begin
      engine_owned_by_processor <= avs_writedata[CSV_CTRL_OWN_BIT];
    end
  end

  // Channels still empty at a session boundary resend their previous octet.
  always_ff @(posedge clk) begin
    if (srst) begin
      tx_repeat <= '0;
    end else if (session_start) begin
      tx_repeat <= empty_all;
    end
  end

  // Events are gathered per block, not per channel: software learns that some channel
  // needs service and then scans the status words, skipping those with a clear summary.
  // Events feeding the sticky interrupt status.
  always_comb begin
    irq_events = '0;
    irq_events[CSV_IRQ_RX_FULL] = rx_deliver;
    irq_events[CSV_IRQ_TX_EMPTY] = tx_consumed;
    irq_events[CSV_IRQ_ABORT] = rx_deliver & rx_abort;
    irq_events[CSV_IRQ_CRC] = rx_deliver & rx_crc_err;
    irq_events[CSV_IRQ_OVERRUN] = |overrun_all;
    irq_events[CSV_IRQ_DENIED] = denied & ack;
  end

  csv_irq #(
    .W(CSV_IRQ_W)
  ) u_irq (
    .clk(clk),
    .srst(srst),
    .event_in(irq_events),
    .clear_wr(wr_fire && lane0 && avs_address == CSV_IRQ_STAT_IDX),
    .mask_wr(wr_fire && lane0 && avs_address == CSV_IRQ_MASK_IDX),
    .wr_data(avs_writedata[CSV_IRQ_W-1:0]),
    .status(irq_status),
    .mask(irq_mask),
    .irq(irq)
  );

  // Sequences describing one bus read of a status word.
  sequence s_vec_read_owned;
    avs_read && avs_waitrequest && is_vec && engine_owned_by_processor;
  endsequence

  sequence s_vec_read_locked;
    avs_read && avs_waitrequest && is_vec && !engine_owned_by_processor;
  endsequence

  chk_vec_read_value: assert property (@(posedge clk) disable iff (srst)
    s_vec_read_owned |=> !avs_waitrequest &&
      avs_readdata[CSV_VEC_BITS-1:0] == $past(vec_all[vec_sel]))
    else $error("Status word read returned the wrong value.");

  chk_locked_reads_zero: assert property (@(posedge clk) disable iff (srst)
    s_vec_read_locked |=> !avs_waitrequest && avs_readdata == '0 ##1
      irq_status[CSV_IRQ_DENIED])
    else $error("Status word visible without ownership.");

  chk_unused_bits_zero: assert property (@(posedge clk) disable iff (srst)
    s_vec_read_owned |=> avs_readdata[15:CSV_VEC_BITS] == '0)
    else $error("Unused status word bits are not zero.");

  chk_repeat_capture: assert property (@(posedge clk) disable iff (srst)
    session_start |=> tx_repeat == $past(empty_all))
    else $error("Repeat mask does not match empty slots at session start.");

  chk_wait_answer: assert property (@(posedge clk) disable iff (srst)
    req && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("Bus answer not exactly one cycle low.");

  chk_summary_now: assert property (@(posedge clk) disable iff (srst)
    vec_all[0][CSV_BIT_FLAG] == (vec_all[0][CSV_BIT_FULL] | vec_all[0][CSV_BIT_EMPTY]))
    else $error("Summary flag lags the slot flags.");

  // Further bus paths. A write acts at the edge where waitrequest is low, so its
  // effect shows one cycle later; reads are judged on the cycle of their answer.
  sequence s_write_done;
    avs_write && !avs_waitrequest && lane0;
  endsequence

  sequence s_read_other;
    avs_read && avs_waitrequest && !is_vec;
  endsequence

  sequence s_no_write;
    !(avs_write && !avs_waitrequest);
  endsequence

  chk_ctrl_write_lands: assert property (@(posedge clk) disable iff (srst)
    s_write_done ##0 avs_address == CSV_CTRL_IDX |=>
      engine_owned_by_processor == $past(avs_writedata[CSV_CTRL_OWN_BIT]))
    else $error("Ownership bit did not take the written value.");

  // A write without byte lane 0 must leave the ownership bit alone.
  chk_lane_gate: assert property (@(posedge clk) disable iff (srst)
    avs_write && !avs_waitrequest && !lane0 |=> $stable(engine_owned_by_processor))
    else $error("Write without lane 0 changed the ownership bit.");

  chk_own_holds: assert property (@(posedge clk) disable iff (srst)
    s_no_write |=> $stable(engine_owned_by_processor))
    else $error("Ownership bit moved without a write.");

  chk_ctrl_readback: assert property (@(posedge clk) disable iff (srst)
    s_read_other ##0 avs_address == CSV_CTRL_IDX |=>
      avs_readdata == CSV_DATA_W'($past(engine_owned_by_processor)))
    else $error("Control read returned the wrong ownership bit.");

  chk_unmapped_zero: assert property (@(posedge clk) disable iff (srst)
    s_read_other ##0 avs_address != CSV_CTRL_IDX && avs_address != CSV_IRQ_STAT_IDX &&
      avs_address != CSV_IRQ_MASK_IDX |=> avs_readdata == '0)
    else $error("Unmapped read returned nonzero data.");

  chk_mask_readback: assert property (@(posedge clk) disable iff (srst)
    s_read_other ##0 avs_address == CSV_IRQ_MASK_IDX |=>
      avs_readdata == CSV_DATA_W'($past(irq_mask)))
    else $error("Mask read returned the wrong value.");

  chk_stat_readback: assert property (@(posedge clk) disable iff (srst)
    s_read_other ##0 avs_address == CSV_IRQ_STAT_IDX |=>
      avs_readdata == CSV_DATA_W'($past(irq_status)))
    else $error("Status read returned the wrong value.");

  chk_clear_lands: assert property (@(posedge clk) disable iff (srst)
    s_write_done ##0 avs_address == CSV_IRQ_STAT_IDX && irq_events == '0 |=>
      (irq_status & $past(avs_writedata[CSV_IRQ_W-1:0])) == '0)
    else $error("Written ones did not clear interrupt status.");

  chk_mask_lands: assert property (@(posedge clk) disable iff (srst)
    s_write_done ##0 avs_address == CSV_IRQ_MASK_IDX |=>
      irq_mask == $past(avs_writedata[CSV_IRQ_W-1:0]))
    else $error("Mask did not take the written value.");

  // Read data stands until the next read answer, so a late look sees the last one.
  chk_readdata_holds: assert property (@(posedge clk) disable iff (srst)
    !(avs_read && avs_waitrequest) |=> $stable(avs_readdata))
    else $error("Read data changed without a read answer.");

  chk_wait_idle: assert property (@(posedge clk) disable iff (srst)
    !req |=> avs_waitrequest)
    else $error("Waitrequest dropped with no request.");

  chk_repeat_holds: assert property (@(posedge clk) disable iff (srst)
    !session_start |=> $stable(tx_repeat))
    else $error("Repeat mask changed between sessions.");

  // The window must take exactly the channel words and nothing around them.
  chk_vec_window: assert property (@(posedge clk) disable iff (srst)
    is_vec == (avs_address >= CSV_VEC_BASE_IDX &&
      avs_address < CSV_VEC_BASE_IDX + CSV_ADDR_W'(NUM_CHANNELS)))
    else $error("Status word window decoded wrongly.");

  // Each engine event leaves its sticky interrupt bit set on the next cycle.
  chk_rx_event_sticky: assert property (@(posedge clk) disable iff (srst)
    rx_deliver |=> irq_status[CSV_IRQ_RX_FULL])
    else $error("Delivery did not set its status bit.");

  chk_tx_event_sticky: assert property (@(posedge clk) disable iff (srst)
    tx_consumed |=> irq_status[CSV_IRQ_TX_EMPTY])
    else $error("Consumption did not set its status bit.");

  chk_abort_event: assert property (@(posedge clk) disable iff (srst)
    rx_deliver && rx_abort |=> irq_status[CSV_IRQ_ABORT])
    else $error("Abort did not set its status bit.");

  chk_crc_event: assert property (@(posedge clk) disable iff (srst)
    rx_deliver && rx_crc_err |=> irq_status[CSV_IRQ_CRC])
    else $error("CRC error did not set its status bit.");

  chk_overrun_event: assert property (@(posedge clk) disable iff (srst)
    |overrun_all |=> irq_status[CSV_IRQ_OVERRUN])
    else $error("Overrun did not set its status bit.");

endmodule

`default_nettype wire

// *** verification/csv_slot_model.sv ***
`timescale 1ns/1ps
`default_nettype none

// Stand-in for the engine and the processor's slot accesses; every event is a one-cycle pulse.
module csv_slot_model (
  // Clock.
  input wire logic clk,
  // Receive octet and qualifiers.
  output logic rx_deliver,
  output logic [4:0] rx_channel,
  output logic rx_partial,
  output logic rx_crc_err,
  output logic rx_stop,
  output logic rx_abort,
  // Slot accesses and session boundary.
  output logic rx_taken,
  output logic [4:0] rx_taken_channel,
  output logic tx_consumed,
  output logic [4:0] tx_consumed_channel,
  output logic tx_written,
  output logic [4:0] tx_written_channel,
  output logic session_start
);
  // Quiet at time zero.
  initial begin
    {rx_deliver, rx_taken, tx_consumed, tx_written, session_start} = 5'h00;
    {rx_channel, rx_taken_channel, tx_consumed_channel, tx_written_channel} = 20'h00000;
    {rx_abort, rx_stop, rx_crc_err, rx_partial} = 4'h0;
  end

  // Kinds: 0 deliver, 1 taken, 2 consumed, 3 written, 4 session. Qualifiers ride the pulse.
  task automatic pulse(input logic [2:0] kind, input logic [4:0] ch, input logic [3:0] q);
    rx_deliver <= (kind == 3'h0);
    rx_channel <= ch;
    {rx_abort, rx_stop, rx_crc_err, rx_partial} <= q;
    rx_taken <= (kind == 3'h1);
    rx_taken_channel <= ch;
    tx_consumed <= (kind == 3'h2);
    tx_consumed_channel <= ch;
    tx_written <= (kind == 3'h3);
    tx_written_channel <= ch;
    session_start <= (kind == 3'h4);
    @(posedge clk);
    // Stale qualifiers are inverted so nothing can lean on a held value.
    {rx_deliver, rx_taken, tx_consumed, tx_written, session_start} <= 5'h00;
    {rx_channel, rx_taken_channel, tx_consumed_channel, tx_written_channel} <= ~{4{ch}};
    {rx_abort, rx_stop, rx_crc_err, rx_partial} <= ~q;
    @(posedge clk);
  endtask
endmodule

`default_nettype wire

// *** verification/hdlc_channel_status_vector_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none

module hdlc_channel_status_vector_tb_top;
  import csv_pkg::*;
  logic clk, srst, avs_read, avs_write, avs_waitrequest, irq, own;
  logic rx_deliver, rx_partial, rx_crc_err, rx_stop, rx_abort, rx_taken, tx_consumed;
  logic tx_written, session_start;
  logic [4:0] rx_channel, rx_taken_channel, tx_consumed_channel, tx_written_channel;
  logic [15:0] avs_address;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, rd, r, tx_repeat, exp_rep, seed;
  logic [6:0] mv [32];
  logic [5:0] mstat;
  int miscompares, checks_done;

  csv_top csv_top_i (.clk, .srst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .rx_deliver, .rx_channel, .rx_partial,
    .rx_crc_err, .rx_stop, .rx_abort, .rx_taken, .rx_taken_channel, .tx_consumed,
    .tx_consumed_channel, .tx_written, .tx_written_channel, .session_start,
    .engine_owned_by_processor(own), .tx_repeat, .irq);
  csv_slot_model csv_slot_model_i (.clk, .rx_deliver, .rx_channel, .rx_partial, .rx_crc_err,
    .rx_stop, .rx_abort, .rx_taken, .rx_taken_channel, .tx_consumed, .tx_consumed_channel,
    .tx_written, .tx_written_channel, .session_start);

  // Clock at 100 ns.
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One Avalon transfer; holds everything until waitrequest is sampled low.
  task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    // Only the watchdog ends a wait that never sees the answer.
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask

  // Drive one event and advance the reference model the same way.
  task automatic apply(input logic [2:0] k, input logic [4:0] c, input logic [3:0] q);
    csv_slot_model_i.pulse(k, c, q);
    case (k)
      3'h0: begin
        if (mv[c][4]) mstat[4] = 1'b1;
        mv[c][3:0] = {q[3], q[2] | q[3], q[1], q[0]};
        mv[c][4] = 1'b1;
        mstat = mstat | {2'b00, q[1], q[3], 2'b01};
      end
      3'h1: mv[c][4:0] = 5'h00;
      3'h2: begin
        mv[c][5] = 1'b1;
        mstat[1] = 1'b1;
      end
      3'h3: mv[c][5] = 1'b0;
      default: ;
    endcase
    mv[c][6] = mv[c][4] | mv[c][5];
  endtask

  task automatic report_and_stop();
    $display("checks_done %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // Watchdog well beyond the thousand or so cycles the sequence needs.
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    report_and_stop();
  end

  // Main sequence: denied read, registers, all words, random traffic, session.
  initial begin
    seed = 32'h5EEB;
    miscompares = 0;
    checks_done = 0;
    {srst, avs_read, avs_write, avs_address, avs_writedata} = {1'b1, 50'h0};
    avs_byteenable = 4'hF;
    mstat = 6'h20;
    for (int c = 0; c < 32; c++) mv[c] = 7'h60;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    bus(1'b0, CSV_VEC_BASE_IDX, 32'h0, rd);
    check(rd, 32'h0);
    bus(1'b0, CSV_IRQ_STAT_IDX, 32'h0, rd);
    check(rd, {26'h0, mstat});
    check({31'h0, irq}, 32'h0);
    bus(1'b1, CSV_CTRL_IDX, 32'h1, rd);
    bus(1'b1, CSV_IRQ_MASK_IDX, 32'h3F, rd);
    check({31'h0, irq}, 32'h1);
    bus(1'b0, CSV_CTRL_IDX, 32'h0, rd);
    check(rd, 32'h1);
    check({31'h0, own}, 32'h1);
    avs_byteenable <= 4'hE;
    bus(1'b1, CSV_CTRL_IDX, 32'h0, rd);
    avs_byteenable <= 4'hF;
    check({31'h0, own}, 32'h1);
    bus(1'b0, 16'h4103, 32'h0, rd);
    check(rd, 32'h0);
    bus(1'b1, CSV_VEC_BASE_IDX + 16'h3, 32'hFFFF, rd);
    for (int c = 0; c < 32; c++) begin
      bus(1'b0, CSV_VEC_BASE_IDX + 16'(c), 32'h0, rd);
      check(rd, {25'h0, mv[c]});
    end
    apply(3'h0, 5'd7, 4'h8);
    for (int i = 0; i < 60; i++) begin
      if (i > 0) begin
        r = rnd();
        if (r[8] && !mv[r[4:0]][6]) r[8] = 1'b0;
        apply({1'b0, r[9:8]}, r[4:0], r[15:12]);
      end
      r[4:0] = (i > 0) ? r[4:0] : 5'd7;
      bus(1'b0, CSV_VEC_BASE_IDX + {11'h0, r[4:0]}, 32'h0, rd);
      check(rd, {25'h0, mv[r[4:0]]});
      if (mv[r[4:0]][2]) apply(3'h1, r[4:0], 4'h0);
      bus(1'b0, CSV_IRQ_STAT_IDX, 32'h0, rd);
      check(rd, {26'h0, mstat});
      check({31'h0, irq}, {31'h0, mstat != 6'h00});
      bus(1'b1, CSV_IRQ_STAT_IDX, {26'h0, mstat}, rd);
      mstat = 6'h00;
      check({31'h0, irq}, 32'h0);
    end
    apply(3'h4, 5'd0, 4'h0);
    for (int c = 0; c < 32; c++) exp_rep[c] = mv[c][5];
    @(posedge clk);
    check(tx_repeat, exp_rep);
    report_and_stop();
  end
endmodule

`default_nettype wire
